// *** rtl/rx_hdlc_block_ram_config.sv ***
// receive hdlc register bank: indirect block links, bit order, length check
`timescale 1ns/1ps
// Functional notes
// RL1: block index field picks the link entry accessed
// RL2: select write with read bit low stores data register into entry
// RL3: select write with read bit high loads entry into data register
// RL4: busy rises on select write, falls when access finishes
// RL5: software waits for busy low before reading data or writing again
// RL6: each entry holds the 11-bit number of the following block
// RL7: software links a channel's blocks into a closed circle
// RL8: data register returns last write until a read completes
// RL9: software rewrites all links of a fifo when provisioning it
// RL10: software writes zero to reserved bits
// RL11: any enabled lane writes all bits; no lanes means no write
// RL12: bit order clear puts first received bit in byte lsb
// RL13: bit order set puts first received bit in byte msb
// RL14: length check on aborts oversize frame and drops remainder
// RL15: length check off never aborts; software sets max to all ones
// RL16: length counts address, control, info and fcs bytes, 16-bit max
// RL17: bit order and length check apply to every channel alike
// RL18: select holds busy bit 15, read bit 14, index bits 10..0
// RL19: one link entry for every index value, 2048 in all
module rx_hdlc_block_ram_config
    import rx_hdlc_cfg_pkg::*;
#(
    parameter int BLOCKS = 2048
)(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // register port
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic [3:0]          byte_lane_enables_n,
    output logic [31:0]              reg_rdata,
    output logic                     reg_rdata_valid,
    // received bytes from the hdlc processor, bit 0 received first
    input  wire logic                rx_valid,
    input  wire rx_byte_s            rx_byte,
    // bytes toward the host bus
    output logic                     host_valid,
    output rx_byte_s                 host_byte,
    output logic                     frame_abort
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    access_state_e         state;
    logic [BLOCK_W-1:0]    block_index;
    logic                  block_read_not_write;
    logic [BLOCK_W-1:0]    next_block_pointer;
    logic                  data_reserved;
    logic                  msb_first_bit_order;
    logic                  length_check_enable;
    logic [MAXLEN_W-1:0]   max_frame_length;
    logic                  access_start;
    logic                  ram_done;
    logic [BLOCK_W-1:0]    ram_rdata;
    logic                  busy;
    logic                  write_ok;
    logic                  sel_write;

    assign busy      = (state == ACC_WAIT);
    // RL11: lanes ignored, all-off blocks
    assign write_ok  = reg_write && (byte_lane_enables_n != LANES_ALL_OFF);
    assign sel_write = write_ok && (reg_addr == OFF_BLOCK_SELECT);

    // ------------------------------------------------------------------
    // indirect access control
    // ------------------------------------------------------------------
    // RL4: busy from select write
    // select writes while busy are dropped so a running access stays intact
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state        <= ACC_IDLE;
            access_start <= 1'b0;
        end
        else
        begin
            access_start <= 1'b0;
            unique case (state)
                ACC_IDLE:
                begin
                    if (sel_write)
                    begin
                        state        <= ACC_WAIT;
                        access_start <= 1'b1;
                    end
                end
                ACC_WAIT:
                begin
                    if (ram_done)
                    begin
                        state <= ACC_IDLE;
                    end
                end
            endcase
        end
    end

    // RL18: select field layout
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            block_index          <= BLOCK_RESET;
            block_read_not_write <= 1'b0;
        end
        else if (sel_write && !busy)
        begin
            block_index          <= reg_wdata[BLOCK_W-1:0];
            block_read_not_write <= reg_wdata[SEL_READ_BIT];
        end
    end

    // RL8: read completion wins over a same-cycle software write
    // RL3: read result into data register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            next_block_pointer <= BLOCK_RESET;
            data_reserved      <= 1'b0;
        end
        else if (ram_done && block_read_not_write)
        begin
            next_block_pointer <= ram_rdata;
        end
        else if (write_ok && reg_addr == OFF_BLOCK_DATA)
        begin
            next_block_pointer <= reg_wdata[BLOCK_W-1:0];
            data_reserved      <= reg_wdata[DATA_RSVD_BIT];
        end
    end

    // RL17: one global setting
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            msb_first_bit_order <= 1'b0;
            length_check_enable <= 1'b0;
            max_frame_length    <= MAX_LENGTH_RESET;
        end
        else if (write_ok && reg_addr == OFF_LINE_CONFIG)
        begin
            msb_first_bit_order <= reg_wdata[CFG_MSB_FIRST_BIT];
            length_check_enable <= reg_wdata[CFG_LENGTH_CHECK_ENABLE_BIT];
        end
        else if (write_ok && reg_addr == OFF_MAX_LENGTH)
        begin
            max_frame_length <= reg_wdata[MAXLEN_W-1:0];
        end
    end

    // RL2: write uses held data
    block_link_ram #(
        .BLOCKS         (BLOCKS)
    ) u_links (
        .clk            (clk),
        .reset_n        (reset_n),
        .start          (access_start),
        .read_not_write (block_read_not_write),
        .index          (block_index),
        .wdata          (next_block_pointer),
        .done           (ram_done),
        .rdata          (ram_rdata)
    );

    // ------------------------------------------------------------------
    // register read-back
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata       <= 32'h0000_0000;
            reg_rdata_valid <= 1'b0;
        end
        else
        begin
            reg_rdata_valid <= reg_read;
            reg_rdata       <= 32'h0000_0000;
            if (reg_read)
            begin
                unique case (reg_addr)
                    OFF_BLOCK_SELECT:
                    begin
                        reg_rdata[SEL_BUSY_BIT]  <= busy;
                        reg_rdata[SEL_READ_BIT]  <= block_read_not_write;
                        reg_rdata[BLOCK_W-1:0]   <= block_index;
                    end
                    OFF_BLOCK_DATA:
                    begin
                        reg_rdata[DATA_RSVD_BIT] <= data_reserved;
                        reg_rdata[BLOCK_W-1:0]   <= next_block_pointer;
                    end
                    OFF_LINE_CONFIG:
                    begin
                        reg_rdata[CFG_MSB_FIRST_BIT] <= msb_first_bit_order;
                        reg_rdata[CFG_LENGTH_CHECK_ENABLE_BIT]    <= length_check_enable;
                    end
                    OFF_MAX_LENGTH:
                    begin
                        reg_rdata[MAXLEN_W-1:0] <= max_frame_length;
                    end
                    default:
                    begin
                        reg_rdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // receive path: length check and bit order
    // ------------------------------------------------------------------
    // one extra bit so a frame of 65535 bytes plus one is still seen
    logic [MAXLEN_W:0] frame_count;
    logic [MAXLEN_W:0] next_count;
    logic              discarding;
    logic              over_length;
    logic [7:0]        reversed;

    assign next_count  = rx_byte.first ? 17'h0_0001
                                       : frame_count + 17'h0_0001;
    // RL16: all fields counted
    // RL15: no abort when off
    assign over_length = length_check_enable
                      && (next_count > {1'b0, max_frame_length});

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            reversed[i] = rx_byte.data[7-i];
        end
    end

    // RL14: abort then discard
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            frame_count <= '0;
            discarding  <= 1'b0;
            frame_abort <= 1'b0;
        end
        else
        begin
            frame_abort <= 1'b0;
            if (rx_valid)
            begin
                if (frame_count != {1'b1, 16'h0000} || rx_byte.first)
                begin
                    frame_count <= next_count;
                end
                if ((!discarding || rx_byte.first) && over_length)
                begin
                    frame_abort <= 1'b1;
                    discarding  <= !rx_byte.last;
                end
                else if (rx_byte.first || rx_byte.last)
                begin
                    discarding  <= 1'b0;
                end
            end
        end
    end

    // RL12: lsb first by default
    // RL13: msb first when set
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            host_valid <= 1'b0;
            host_byte  <= '0;
        end
        else
        begin
            host_valid <= rx_valid && !over_length
                       && (!discarding || rx_byte.first);
            host_byte.first <= rx_byte.first;
            host_byte.last  <= rx_byte.last;
            host_byte.data  <= msb_first_bit_order ? reversed
                                                   : rx_byte.data;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    localparam int ACC_MAX = 3;

    sequence s_select_write_idle;
        sel_write && !busy;
    endsequence

    sequence s_access_ends;
        ##[1:ACC_MAX] !busy;
    endsequence

    a_busy_on_select: assert property ( // RL4
        s_select_write_idle |=> busy)
        else $error("busy not raised by select write");

    a_busy_clears: assert property ( // RL4
        s_select_write_idle |=> busy ##0 s_access_ends)
        else $error("busy not cleared after access");

    a_read_loads_data: assert property ( // RL3
        ram_done && block_read_not_write |=> next_block_pointer
            == $past(ram_rdata))
        else $error("read result not placed in data register");

    a_index_taken: assert property ( // RL1
        s_select_write_idle |=> block_index == $past(reg_wdata[10:0]))
        else $error("block index not taken from select write");

    a_lanes_off_hold: assert property ( // RL11
        reg_write && byte_lane_enables_n == LANES_ALL_OFF
            |=> $stable(max_frame_length) && $stable(msb_first_bit_order))
        else $error("write with no lanes changed a register");

    a_data_holds: assert property ( // RL8
        !(write_ok && reg_addr == OFF_BLOCK_DATA) && !ram_done
            |=> $stable(next_block_pointer))
        else $error("data register changed without cause");

    a_bit_order: assert property ( // RL13
        rx_valid && msb_first_bit_order && !over_length && !discarding
            |=> host_valid && host_byte.data[7] == $past(rx_byte.data[0]))
        else $error("first received bit not at msb");

    a_lsb_order: assert property ( // RL12
        rx_valid && !msb_first_bit_order
            |=> host_byte.data[0] == $past(rx_byte.data[0]))
        else $error("first received bit not at lsb");

    a_abort_len: assert property ( // RL14
        rx_valid && over_length && !discarding |=> frame_abort && !host_valid)
        else $error("oversize frame not aborted");

    a_no_abort_off: assert property ( // RL15
        !length_check_enable |=> !frame_abort)
        else $error("abort raised with length check off");

endmodule // rx_hdlc_block_ram_config

// *** rtl/rx_hdlc_cfg_pkg.sv ***
// shared constants and types for the receive hdlc configuration bank
package rx_hdlc_cfg_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int BLOCK_W  = 11;
    localparam int ADDR_W   = 12;
    localparam int MAXLEN_W = 16;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_BLOCK_SELECT = 12'h0210;
    localparam logic [ADDR_W-1:0] OFF_BLOCK_DATA   = 12'h0214;
    localparam logic [ADDR_W-1:0] OFF_LINE_CONFIG  = 12'h0220;
    localparam logic [ADDR_W-1:0] OFF_MAX_LENGTH   = 12'h0224;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int SEL_BUSY_BIT      = 15;
    localparam int SEL_READ_BIT      = 14;
    localparam int DATA_RSVD_BIT     = 11;
    localparam int CFG_MSB_FIRST_BIT = 8;
    localparam int CFG_LENGTH_CHECK_ENABLE_BIT    = 9;

    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic [MAXLEN_W-1:0] MAX_LENGTH_RESET = 16'hFFFF;
    localparam logic [BLOCK_W-1:0]  BLOCK_RESET      = 11'h000;
    localparam logic [3:0]          LANES_ALL_OFF    = 4'hF;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       first;
        logic       last;
        logic [7:0] data;
    } rx_byte_s;

    typedef enum logic {
        ACC_IDLE,
        ACC_WAIT
    } access_state_e;

endpackage

// *** rtl/block_link_ram.sv ***
// block pointer storage with a one-cycle indirect access port
`timescale 1ns/1ps
module block_link_ram
    import rx_hdlc_cfg_pkg::*;
#(
    parameter int BLOCKS = 2048
)(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // access request
    input  wire logic               start,
    input  wire logic               read_not_write,
    input  wire logic [BLOCK_W-1:0] index,
    input  wire logic [BLOCK_W-1:0] wdata,
    // access answer
    output logic                    done,
    output logic [BLOCK_W-1:0]      rdata
);

    // RL6: 11-bit next-block links
    logic [BLOCK_W-1:0] links [BLOCKS];

    // last stored entry, kept only so the read-back check has a reference
    logic               seen_write;
    logic [BLOCK_W-1:0] seen_index;
    logic [BLOCK_W-1:0] seen_data;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // RL19: entry per index
    // RL2: store on write
    always_ff @(posedge clk)
    begin
        if (start && !read_not_write)
        begin
            links[index] <= wdata;
        end
    end

    // RL1: index selects entry
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rdata <= BLOCK_RESET;
        end
        else if (start && read_not_write)
        begin
            rdata <= links[index];
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= start;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // accesses never start back to back, so track the last write instead
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            seen_write <= 1'b0;
            seen_index <= BLOCK_RESET;
            seen_data  <= BLOCK_RESET;
        end
        else if (start && !read_not_write)
        begin
            seen_write <= 1'b1;
            seen_index <= index;
            seen_data  <= wdata;
        end
    end

    a_done_follows: assert property ( // RL4
        @(posedge clk) disable iff (!reset_n)
        start |=> done)
        else $error("access did not complete one cycle after start");

    a_write_read_back: assert property ( // RL6
        @(posedge clk) disable iff (!reset_n)
        start && read_not_write && seen_write && index == seen_index
            |=> rdata == $past(seen_data))
        else $error("stored pointer not returned by read");

endmodule // block_link_ram

// *** verification/rx_hdlc_block_ram_config_tb_top.sv ***
// self-checking bench for the receive hdlc configuration register bank
`timescale 1ns/1ps
module rx_hdlc_block_ram_config_tb_top
    import rx_hdlc_cfg_pkg::*;
;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic              clk;
    logic              reset_n;
    logic              reg_write;
    logic              reg_read;
    logic [ADDR_W-1:0] reg_addr;
    logic [31:0]       reg_wdata;
    logic [3:0]        byte_lane_enables_n;
    logic [31:0]       reg_rdata;
    logic              reg_rdata_valid;
    logic              rx_valid;
    rx_byte_s          rx_byte;
    logic              host_valid;
    rx_byte_s          host_byte;
    logic              frame_abort;
    int                error_cnt;
    int                checks;
    logic [BLOCK_W-1:0] blk [4];

    rx_hdlc_block_ram_config #(
        .BLOCKS (2048)
    ) dut (
        .clk                 (clk),
        .reset_n             (reset_n),
        .reg_write           (reg_write),
        .reg_read            (reg_read),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .byte_lane_enables_n (byte_lane_enables_n),
        .reg_rdata           (reg_rdata),
        .reg_rdata_valid     (reg_rdata_valid),
        .rx_valid            (rx_valid),
        .rx_byte             (rx_byte),
        .host_valid          (host_valid),
        .host_byte           (host_byte),
        .frame_abort         (frame_abort)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] bit_rev(input logic [7:0] d);
        logic [7:0] r;
        for (int i = 0; i < 8; i++)
            r[i] = d[7-i];
        return r;
    endfunction

    // ------------------------------------------------------------------
    // register port: strobes stay up until the next access or an idle
    // ------------------------------------------------------------------
    task automatic reg_wr(input logic [ADDR_W-1:0] addr,
                          input logic [31:0] data, input logic [3:0] lanes_n);
        reg_write           = 1'b1;
        reg_read            = 1'b0;
        reg_addr            = addr;
        reg_wdata           = data;
        byte_lane_enables_n = lanes_n;
        @(negedge clk);
    endtask

    task automatic reg_rd(input logic [ADDR_W-1:0] addr,
                          output logic [31:0] data);
        reg_write = 1'b0;
        reg_read  = 1'b1;
        reg_addr  = addr;
        @(negedge clk);
        chk_bit(reg_rdata_valid, 1'b1);
        data = reg_rdata;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] addr,
                          input logic [31:0] exp);
        logic [31:0] v;
        reg_rd(addr, v);
        chk_word(v, exp);
    endtask

    task automatic reg_idle();
        reg_write = 1'b0;
        reg_read  = 1'b0;
        @(negedge clk);
    endtask

    // busy polled with reads back to back, bounded
    task automatic indirect(input logic [BLOCK_W-1:0] idx, input logic rd);
        logic [31:0] w;
        int          n;
        w = 32'h0000_0000;
        w[SEL_READ_BIT] = rd;
        w[BLOCK_W-1:0]  = idx;
        reg_wr(OFF_BLOCK_SELECT, w, 4'h0);
        reg_rd(OFF_BLOCK_SELECT, w);
        chk_bit(w[SEL_BUSY_BIT], 1'b1);
        n = 0;
        while (w[SEL_BUSY_BIT] !== 1'b0 && n < 8)
        begin
            reg_rd(OFF_BLOCK_SELECT, w);
            n++;
        end
        if (w[SEL_BUSY_BIT] !== 1'b0)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, w, idx);
            test_done();
        end
    endtask

    // ------------------------------------------------------------------
    // receive path: one byte per cycle, outputs seen one cycle later
    // ------------------------------------------------------------------
    task automatic rx_send(input logic first, input logic last,
                           input logic [7:0] data, input logic exp_v,
                           input logic [7:0] exp_d, input logic exp_abort);
        rx_valid      = 1'b1;
        rx_byte.first = first;
        rx_byte.last  = last;
        rx_byte.data  = data;
        @(negedge clk);
        chk_bit(host_valid, exp_v);
        chk_bit(frame_abort, exp_abort);
        if (exp_v)
            chk_word({22'h0, host_byte}, {22'h0, first, last, exp_d});
    endtask

    task automatic rx_idle();
        rx_valid = 1'b0;
        @(negedge clk);
    endtask

    initial
    begin
        #800000;
        error_cnt++;
        $display("unexpected at %0t: got %h expected %h", $time, 0, 1);
        test_done();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        error_cnt           = 0;
        checks              = 0;
        reset_n             = 1'b0;
        reg_write           = 1'b0;
        reg_read            = 1'b0;
        reg_addr            = '0;
        reg_wdata           = 32'h0000_0000;
        byte_lane_enables_n = 4'hF;
        rx_valid            = 1'b0;
        rx_byte             = '0;
        blk[0] = 11'h000;
        blk[1] = 11'h005;
        blk[2] = 11'h400;
        blk[3] = 11'h7FF;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        rd_chk(OFF_BLOCK_SELECT, 32'h0000_0000);
        rd_chk(OFF_BLOCK_DATA, 32'h0000_0000);
        rd_chk(OFF_LINE_CONFIG, 32'h0000_0000);
        rd_chk(OFF_MAX_LENGTH, 32'h0000_FFFF);
        rd_chk(12'h0218, 32'h0000_0000);
        // closed circle over four blocks, top index included
        for (int i = 0; i < 4; i++)
        begin
            reg_wr(OFF_BLOCK_DATA, {21'h0, blk[(i+1)%4]}, 4'h0);
            indirect(blk[i], 1'b0);
        end
        reg_wr(OFF_BLOCK_DATA, 32'h0000_06BC, 4'h0);
        rd_chk(OFF_BLOCK_DATA, 32'h0000_06BC);
        for (int i = 0; i < 4; i++)
        begin
            indirect(blk[i], 1'b1);
            rd_chk(OFF_BLOCK_DATA, {21'h0, blk[(i+1)%4]});
            rd_chk(OFF_BLOCK_SELECT, {17'h0, 1'b1, 3'h0, blk[i]});
        end
        // lanes all off leave the register alone, any one writes all
        reg_wr(OFF_LINE_CONFIG, 32'h0000_0300, 4'hF);
        rd_chk(OFF_LINE_CONFIG, 32'h0000_0000);
        reg_wr(OFF_MAX_LENGTH, 32'h0000_0003, 4'h7);
        rd_chk(OFF_MAX_LENGTH, 32'h0000_0003);
        reg_wr(OFF_LINE_CONFIG, 32'h0000_0200, 4'hE);
        rd_chk(OFF_LINE_CONFIG, 32'h0000_0200);
        reg_idle();
        // fourth byte crosses the limit of three
        for (int k = 1; k <= 5; k++)
            rx_send(k == 1, k == 5, 8'(8'h10 + k), k <= 3,
                    8'(8'h10 + k), k == 4);
        rx_idle();
        reg_wr(OFF_MAX_LENGTH, 32'h0000_FFFF, 4'h0);
        reg_wr(OFF_LINE_CONFIG, 32'h0000_0100, 4'h0);
        reg_idle();
        for (int k = 1; k <= 5; k++)
            rx_send(k == 1, k == 5, 8'(8'h30 + k), 1'b1,
                    bit_rev(8'(8'h30 + k)), 1'b0);
        rx_idle();
        reg_wr(OFF_LINE_CONFIG, 32'h0000_0000, 4'h0);
        reg_idle();
        rx_send(1'b1, 1'b1, 8'h01, 1'b1, 8'h01, 1'b0);
        rx_send(1'b1, 1'b1, 8'hC5, 1'b1, 8'hC5, 1'b0);
        rx_idle();
        test_done();
    end

endmodule // rx_hdlc_block_ram_config_tb_top
